// ===== bridge_pins_regs.vh
`ifndef BRIDGE_PINS_REGS_VH
`define BRIDGE_PINS_REGS_VH

// Register byte offsets
`define OFF_CTRL        12'h000
`define OFF_STATUS      12'h004
`define OFF_IRQ_STATUS  12'h008
`define OFF_IRQ_MASK    12'h00c
`define OFF_VOLUME      12'h010
`define OFF_CONFIG_CLOCK_OUT_DIV  12'h014
`define OFF_UART        12'h018

// Control register fields
`define CTRL_SYSTEM_CLOCK_SEL 0
`define CTRL_SRC_SEL    2
`define CTRL_BUS_RATE   5
`define CTRL_RESET_VAL  32'h00000000

// Interrupt status bits
`define EV_PLAYBACK_MUTE_TOGGLE_IN        0
`define EV_RECORD_MUTE_TOGGLE_IN        1
`define EV_VOL_DN       2
`define EV_VOL_UP       3
`define EV_RESET_REQ    4
`define EV_WIDTH        5

// Volume
`define VOL_RESET       8'h80
`define VOL_MAX         8'hff
`define VOL_MIN         8'h00

// Timing, in the stated units
`define CLK_HZ          20000000
`define DEBOUNCE_US     5000
`define RESET_MIN_US    15
`define RESET_MIN_CYC   ((`RESET_MIN_US * (`CLK_HZ / 1000000)))
`define DEBOUNCE_CYC    ((`DEBOUNCE_US * (`CLK_HZ / 1000000)))
`define ACT_TOGGLE_HZ   20
`define ACT_HALF_CYC    (`CLK_HZ / (2 * `ACT_TOGGLE_HZ))
`define BUS_400K_HZ     400000
`define BUS_100K_HZ     100000
`define BUS_400K_HALF   (`CLK_HZ / (2 * `BUS_400K_HZ))
`define BUS_100K_HALF   (`CLK_HZ / (2 * `BUS_100K_HZ))
`define POR_CYC         16
`define CONFIG_CLOCK_OUT_DIV_RST  16'h0004

// Master clock ratios to system clock
`define MCLK_HZ_48      12000000
`define MCLK_HZ_49      12288000
`define SYS_HZ_48       48000000
`define SYS_HZ_49       49152000

`endif

// ===== audio_bridge_pins.v
// Notes on behaviour
// - Playback mute flips on each low press
// - Record mute flips on each low press
// - Volume down press lowers one step
// - Volume up press raises one step
// - Record mute LED low while muted
// - Transmit activity toggles, idles high
// - Receive activity toggles, idles high
// - Two suspend outputs, opposite polarity
// - Open-drain reset pin, internal and external
// - Master clock is system clock over four
// - Bus rate bit: clear 400k, set 100k
// - Request-to-send output active low
// - Muted record sends zero samples
// - Four straps pick DAC configuration
// - Clock output frequency is configurable
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`include "bridge_pins_regs.vh"

module audio_bridge_pins #(
  parameter DEBOUNCE_CYCLES = `DEBOUNCE_CYC,
  parameter ACT_HALF_CYCLES = `ACT_HALF_CYC,
  parameter SAMPLE_W        = 16
)(
  input  wire                pclk,
  input  wire                presetn,
  input  wire                psel,
  input  wire                penable,
  input  wire                pwrite,
  input  wire [11:0]         paddr,
  input  wire [31:0]         pwdata,
  output reg  [31:0]         prdata,
  output reg                 pready,
  output reg                 pslverr,
  input  wire                playback_mute_toggle_in,
  input  wire                record_mute_toggle_in,
  input  wire                volume_down_in,
  input  wire                volume_up_in,
  output reg                 record_muted_led_out,
  output reg                 playback_muted,
  output reg  [7:0]          volume_level,
  input  wire                uart_tx_busy,
  input  wire                uart_rx_busy,
  output reg                 tx_activity_out,
  output reg                 rx_activity_out,
  input  wire                uart_rx_space,
  output reg                 rts_n_out,
  input  wire                cts_n_in,
  output reg                 tx_permit,
  input  wire                usb_suspend,
  output reg                 suspend_n_out,
  output reg                 suspend_out,
  input  wire                reset_pin_in,
  output reg                 reset_pin_out,
  output reg                 reset_pin_oe_n,
  output reg                 system_reset_req,
  input  wire                dac_select_strap_0,
  input  wire                dac_select_strap_1,
  input  wire                dac_select_strap_2,
  input  wire                dac_select_strap_3,
  output reg  [3:0]          dac_config,
  input  wire                system_clock,
  input  wire                external_system_clock_in,
  output reg                 mclk_out,
  output reg                 config_clock_out,
  output reg                 ctrl_bus_clk,
  input  wire [SAMPLE_W-1:0] rec_sample_in,
  output reg  [SAMPLE_W-1:0] rec_sample_out,
  output reg                 irq
);

  // Input synchronisers, two stages each
  wire [11:0] async_in = {dac_select_strap_3, dac_select_strap_2, dac_select_strap_1,
                          dac_select_strap_0, external_system_clock_in, system_clock,
                          cts_n_in, reset_pin_in, volume_up_in, volume_down_in,
                          record_mute_toggle_in, playback_mute_toggle_in};
  reg  [11:0] sync1;
  reg  [11:0] sync2;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1 <= 12'hfff;
      sync2 <= 12'hfff;
    end
    else
    begin
      sync1 <= async_in;
      sync2 <= sync1;
    end
  end

  // Control registers
  reg [31:0]           ctrl;
  reg [15:0]           config_clock_out_div;
  reg [`EV_WIDTH-1:0]  irq_status;
  reg [`EV_WIDTH-1:0]  irq_mask;
  wire                 wr_en = psel & penable & pwrite;
  wire                 rd_en = psel & ~penable & ~pwrite;
  wire [`EV_WIDTH-1:0] events;

  // Debounce and falling edge per button
  reg  [3:0] btn_stable;
  wire [3:0] btn_press;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : btn
      reg [23:0] cnt;
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          cnt           <= 24'h000000;
          btn_stable[g] <= 1'b1;
        end
        else if (sync2[g] == btn_stable[g])
          cnt <= 24'h000000;
        else if (cnt == DEBOUNCE_CYCLES[23:0] - 24'h000001)
        begin
          cnt           <= 24'h000000;
          btn_stable[g] <= sync2[g];
        end
        else
          cnt <= cnt + 24'h000001;
      end
      assign btn_press[g] = btn_stable[g] & ~sync2[g] &
                            (cnt == DEBOUNCE_CYCLES[23:0] - 24'h000001);
    end
  endgenerate

  // Mute toggles and volume steps
  reg record_muted;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      playback_muted       <= 1'b0;
      record_muted         <= 1'b0;
      record_muted_led_out <= 1'b1;
      volume_level         <= `VOL_RESET;
      rec_sample_out       <= {SAMPLE_W{1'b0}};
    end
    else
    begin
      if (btn_press[0])
        playback_muted <= ~playback_muted;
      if (btn_press[1])
        record_muted <= ~record_muted;
      record_muted_led_out <= ~(record_muted ^ btn_press[1]);
      if (btn_press[2] && volume_level != `VOL_MIN)
        volume_level <= volume_level - 8'h01;
      else if (btn_press[3] && volume_level != `VOL_MAX)
        volume_level <= volume_level + 8'h01;
      rec_sample_out <= record_muted ? {SAMPLE_W{1'b0}} : rec_sample_in;
    end
  end

  reg [23:0] tx_cnt;
  reg [23:0] rx_cnt;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_cnt          <= 24'h000000;
      rx_cnt          <= 24'h000000;
      tx_activity_out <= 1'b1;
      rx_activity_out <= 1'b1;
    end
    else
    begin
      if (!uart_tx_busy)
      begin
        tx_cnt          <= 24'h000000;
        tx_activity_out <= 1'b1;
      end
      else if (tx_cnt == ACT_HALF_CYCLES[23:0] - 24'h000001)
      begin
        tx_cnt          <= 24'h000000;
        tx_activity_out <= ~tx_activity_out;
      end
      else
        tx_cnt <= tx_cnt + 24'h000001;
      if (!uart_rx_busy)
      begin
        rx_cnt          <= 24'h000000;
        rx_activity_out <= 1'b1;
      end
      else if (rx_cnt == ACT_HALF_CYCLES[23:0] - 24'h000001)
      begin
        rx_cnt          <= 24'h000000;
        rx_activity_out <= ~rx_activity_out;
      end
      else
        rx_cnt <= rx_cnt + 24'h000001;
    end
  end

  // Flow control and suspend indicators
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rts_n_out     <= 1'b1;
      tx_permit     <= 1'b0;
      suspend_n_out <= 1'b1;
      suspend_out   <= 1'b0;
    end
    else
    begin
      rts_n_out     <= ~uart_rx_space;
      tx_permit     <= ~sync2[5];
      suspend_n_out <= ~usb_suspend;
      suspend_out   <= usb_suspend;
    end
  end

  reg [4:0]  por_cnt;
  reg [11:0] rst_low_cnt;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      por_cnt          <= 5'h00;
      reset_pin_out    <= 1'b0;
      reset_pin_oe_n   <= 1'b0;
      rst_low_cnt      <= 12'h000;
      system_reset_req <= 1'b0;
    end
    else
    begin
      if (por_cnt != `POR_CYC)
        por_cnt <= por_cnt + 5'h01;
      reset_pin_oe_n <= (por_cnt == `POR_CYC);
      if (sync2[4] || !reset_pin_oe_n)
        rst_low_cnt <= 12'h000;
      else if (rst_low_cnt != `RESET_MIN_CYC)
        rst_low_cnt <= rst_low_cnt + 12'h001;
      system_reset_req <= (rst_low_cnt == `RESET_MIN_CYC);
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dac_config <= 4'h0;
    else if (por_cnt == 5'h02)
      dac_config <= sync2[11:8];
  end

  // Master clock from system clock edges
  wire       clk_src  = ctrl[`CTRL_SRC_SEL] ? sync2[7] : sync2[6];
  reg        clk_src_d;
  reg        mclk_div;
  reg [15:0] co_cnt;
  reg [7:0]  bus_cnt;
  localparam integer BUS_SLOW_HALF = `BUS_100K_HALF;
  localparam integer BUS_FAST_HALF = `BUS_400K_HALF;
  wire [7:0] bus_half = ctrl[`CTRL_BUS_RATE] ? BUS_SLOW_HALF[7:0] : BUS_FAST_HALF[7:0];
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clk_src_d        <= 1'b1;
      mclk_div         <= 1'b0;
      mclk_out         <= 1'b0;
      co_cnt           <= 16'h0000;
      config_clock_out <= 1'b0;
      bus_cnt          <= 8'h00;
      ctrl_bus_clk     <= 1'b1;
    end
    else
    begin
      clk_src_d <= clk_src;
      if (clk_src & ~clk_src_d)
      begin
        mclk_div <= ~mclk_div;
        if (mclk_div)
          mclk_out <= ~mclk_out;
      end
      if (co_cnt >= config_clock_out_div - 16'h0001)
      begin
        co_cnt           <= 16'h0000;
        config_clock_out <= ~config_clock_out;
      end
      else
        co_cnt <= co_cnt + 16'h0001;
      if (bus_cnt >= bus_half - 8'h01)
      begin
        bus_cnt      <= 8'h00;
        ctrl_bus_clk <= ~ctrl_bus_clk;
      end
      else
        bus_cnt <= bus_cnt + 8'h01;
    end
  end

  // Sticky events, set wins over clear
  assign events = {system_reset_req, btn_press[3], btn_press[2], btn_press[1], btn_press[0]};

  // APB slave, zero wait states
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl       <= `CTRL_RESET_VAL;
      config_clock_out_div <= `CONFIG_CLOCK_OUT_DIV_RST;
      irq_status <= {`EV_WIDTH{1'b0}};
      irq_mask   <= {`EV_WIDTH{1'b0}};
      prdata     <= 32'h00000000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      irq        <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      if (wr_en)
      begin
        case (paddr)
          `OFF_CTRL:       ctrl       <= pwdata;
          `OFF_IRQ_MASK:   irq_mask   <= pwdata[`EV_WIDTH-1:0];
          `OFF_CONFIG_CLOCK_OUT_DIV: config_clock_out_div <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
          default:         ;
        endcase
      end
      if (wr_en && paddr == `OFF_IRQ_STATUS)
        irq_status <= (irq_status & ~pwdata[`EV_WIDTH-1:0]) | events;
      else
        irq_status <= irq_status | events;
      irq <= |(irq_status & irq_mask);
      if (rd_en)
      begin
        case (paddr)
          `OFF_CTRL:       prdata <= ctrl;
          `OFF_STATUS:     prdata <= {22'h000000, dac_config, usb_suspend,
                                      tx_permit, record_muted, playback_muted, 2'b00};
          `OFF_IRQ_STATUS: prdata <= {27'h0000000, irq_status};
          `OFF_IRQ_MASK:   prdata <= {27'h0000000, irq_mask};
          `OFF_VOLUME:     prdata <= {24'h000000, volume_level};
          `OFF_CONFIG_CLOCK_OUT_DIV: prdata <= {16'h0000, config_clock_out_div};
          `OFF_UART:       prdata <= {30'h00000000, rx_activity_out, tx_activity_out};
          default:         prdata <= 32'h00000000;
        endcase
        pslverr <= (paddr > `OFF_UART) | (paddr[1:0] != 2'b00);
      end
      else if (psel && !penable)
        pslverr <= (paddr > `OFF_UART) | (paddr[1:0] != 2'b00);
    end
  end

endmodule

// ===== bridge_pins_checker_asserts.sv
`timescale 1ns/1ns
module bridge_pins_checker #(
  parameter SAMPLE_W = 16
)(
  input wire                pclk,
  input wire                presetn,
  input wire                record_mute_toggle_in,
  input wire                record_muted_led_out,
  input wire                uart_tx_busy,
  input wire                uart_rx_busy,
  input wire                tx_activity_out,
  input wire                rx_activity_out,
  input wire                uart_rx_space,
  input wire                rts_n_out,
  input wire                cts_n_in,
  input wire                tx_permit,
  input wire                usb_suspend,
  input wire                suspend_n_out,
  input wire                suspend_out,
  input wire                reset_pin_in,
  input wire                reset_pin_out,
  input wire                system_reset_req,
  input wire [SAMPLE_W-1:0] rec_sample_out
);
  reg [15:0] low_cnt;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Cycles the reset line has been seen low
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      low_cnt <= 16'h0000;
    else if (reset_pin_in)
      low_cnt <= 16'h0000;
    else if (low_cnt != 16'hffff)
      low_cnt <= low_cnt + 16'h0001;
  a_led_needs_press: assert property (
    $past(presetn) && $changed(record_muted_led_out) |-> !$past(record_mute_toggle_in, 3))
    else $error("record led moved without a press");
  a_muted_zero_out: assert property (
    !$past(record_muted_led_out) |-> rec_sample_out == '0)
    else $error("sample passed while muted");
  a_suspend_pair: assert property (
    $past(presetn) |-> suspend_out == $past(usb_suspend) && suspend_n_out == !suspend_out)
    else $error("suspend outputs wrong");
  a_rts_low_ready: assert property (
    $past(presetn) |-> rts_n_out == !$past(uart_rx_space))
    else $error("rts not inverse of space");
  a_cts_permit: assert property (
    $stable(cts_n_in) [*5] |-> tx_permit == !cts_n_in)
    else $error("permit does not follow cts");
  a_tx_idle_high: assert property (
    $past(presetn) && !$past(uart_tx_busy) |-> tx_activity_out)
    else $error("tx activity not high at idle");
  a_rx_idle_high: assert property (
    $past(presetn) && !$past(uart_rx_busy) |-> rx_activity_out)
    else $error("rx activity not high at idle");
  a_pin_only_low: assert property (
    reset_pin_out == 1'b0)
    else $error("reset pin driven high");
  a_hold_minimum: assert property (
    $rose(system_reset_req) |-> low_cnt >= 16'd300)
    else $error("reset request too early");
  a_hold_answered: assert property (
    low_cnt == 16'd310 |-> system_reset_req)
    else $error("reset request missing");
endmodule
bind audio_bridge_pins bridge_pins_checker #(.SAMPLE_W(SAMPLE_W)) u_chk (.*);

// ===== far_side_panel.sv
`timescale 1ns/1ns
module far_side_panel (
  input  wire [3:0] press,
  input  wire       ext_pull,
  input  wire       reset_pin_out,
  input  wire       reset_pin_oe_n,
  output wire       playback_mute_toggle_in,
  output wire       record_mute_toggle_in,
  output wire       volume_down_in,
  output wire       volume_up_in,
  output wire       reset_pin_in,
  output reg        system_clock,
  output reg        external_system_clock_in
);
  // Pressed buttons pull low
  assign playback_mute_toggle_in = !press[0];
  assign record_mute_toggle_in = !press[1];
  assign volume_down_in = !press[2];
  assign volume_up_in = !press[3];
  assign reset_pin_in = !ext_pull && (reset_pin_oe_n || reset_pin_out);
  initial
  begin
    system_clock = 1'b0;
    external_system_clock_in = 1'b0;
  end
  always #200 system_clock = !system_clock;
  initial
  begin
    #70;
    forever #200 external_system_clock_in = !external_system_clock_in;
  end
endmodule

// ===== test_audio_bridge_pins.sv
`timescale 1ns/1ns
`include "bridge_pins_regs.vh"
module test_audio_bridge_pins;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0;
  reg         uart_tx_busy = 1'b0;
  reg         uart_rx_busy = 1'b0;
  reg         uart_rx_space = 1'b0;
  reg         cts_n_in = 1'b1;
  reg         usb_suspend = 1'b0;
  reg  [15:0] rec_sample_in = 16'h0;
  reg  [3:0]  press = 4'h0;
  reg         ext_pull = 1'b0;
  reg  [31:0] seed = 32'h1d60;
  reg  [32:0] expq[$];
  reg  [32:0] n;
  reg         v, pt, pr;
  integer     i, nt, nr;
  integer     error_cnt = 0;
  integer     n_tests = 0;
  integer     cyc = 0;
  wire [31:0] prdata;
  wire        pready, pslverr, record_muted_led_out, playback_muted;
  wire [7:0]  volume_level;
  wire        tx_activity_out, rx_activity_out, rts_n_out, tx_permit;
  wire        suspend_n_out, suspend_out, reset_pin_out, reset_pin_oe_n;
  wire        system_reset_req, mclk_out, config_clock_out, ctrl_bus_clk, irq;
  wire        playback_mute_toggle_in, record_mute_toggle_in, reset_pin_in;
  wire        volume_down_in, volume_up_in, system_clock, external_system_clock_in;
  wire [3:0]  dac_config;
  wire [15:0] rec_sample_out;
  wire [31:0] s0 = xs(32'h1d60);
  wire        dac_select_strap_0 = s0[0];
  wire        dac_select_strap_1 = s0[1];
  wire        dac_select_strap_2 = s0[2];
  wire        dac_select_strap_3 = s0[3];
  wire [2:0]  clks = {config_clock_out, mclk_out, ctrl_bus_clk};
  audio_bridge_pins #(.DEBOUNCE_CYCLES(8), .ACT_HALF_CYCLES(4)) u_dut (.*);
  far_side_panel u_far (.*);
  always #25 pclk = !pclk;
  function [31:0] xs(input [31:0] s);
    begin
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      xs = s ^ (s << 5);
    end
  endfunction
  function [32:0] st(input pb, input rc, input pm, input su);
    st = {23'h0, s0[3:0], su, pm, rc, pb, 2'b00};
  endfunction
  task stop_test;
    begin
      $display("errors=%0d checks=%0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task check(input [32:0] s, input [32:0] e);
    begin
      n_tests = n_tests + 1;
      if (s !== e)
      begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d, input [32:0] e);
    begin
      if (!w)
        expq.push_back(e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task rd(input [11:0] a, input [32:0] e);
    apb(1'b0, a, 32'h0, e);
  endtask
  task wr(input [11:0] a, input [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task tap(input integer k, input integer h);
    begin
      press[k] <= 1'b1;
      repeat (h) @(posedge pclk);
      press[k] <= 1'b0;
      repeat (20) @(posedge pclk);
    end
  endtask
  task half(input integer k, input [32:0] e);
    begin
      for (i = 0; i < 3; i = i + 1)
      begin
        v = clks[k];
        n = 0;
        while (clks[k] === v)
        begin
          @(posedge pclk);
          n = n + 1;
        end
      end
      check(n, e);
    end
  endtask
  // Read results against noted expectations
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite)
      check({pslverr, prdata}, expq.pop_front());
  always @(posedge pclk)
  begin
    seed <= xs(seed);
    rec_sample_in <= seed[15:0];
    uart_rx_space <= seed[7];
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt = error_cnt + 1;
      stop_test;
    end
  end
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`OFF_CTRL, `CTRL_RESET_VAL);
    rd(`OFF_VOLUME, {24'h0, `VOL_RESET});
    rd(`OFF_CONFIG_CLOCK_OUT_DIV, {16'h0, `CONFIG_CLOCK_OUT_DIV_RST});
    rd(`OFF_STATUS, st(0, 0, 0, 0));
    rd(12'h01c, {1'b1, 32'h0});
    tap(0, 3);
    tap(0, 20);
    tap(1, 20);
    rd(`OFF_STATUS, st(1, 1, 0, 0));
    check(record_muted_led_out, 0);
    wr(`OFF_IRQ_MASK, 32'h1f);
    @(posedge pclk);
    check(irq, 1);
    rd(`OFF_IRQ_STATUS, 32'h3);
    wr(`OFF_IRQ_STATUS, 32'h3);
    @(posedge pclk);
    check(irq, 0);
    tap(1, 20);
    check(record_muted_led_out, 1);
    repeat (3) tap(2, 20);
    tap(3, 20);
    rd(`OFF_VOLUME, 32'h7e);
    repeat (130) tap(3, 14);
    rd(`OFF_VOLUME, {24'h0, `VOL_MAX});
    uart_tx_busy <= 1'b1;
    uart_rx_busy <= 1'b1;
    nt = 0;
    nr = 0;
    repeat (24)
    begin
      @(posedge pclk);
      pt = tx_activity_out;
      pr = rx_activity_out;
      #1;
      nt = nt + (tx_activity_out !== pt);
      nr = nr + (rx_activity_out !== pr);
    end
    check(nt > 4, 1);
    check(nr > 4, 1);
    @(posedge pclk);
    uart_tx_busy <= 1'b0;
    uart_rx_busy <= 1'b0;
    cts_n_in <= 1'b0;
    usb_suspend <= 1'b1;
    repeat (6) @(posedge pclk);
    rd(`OFF_STATUS, st(1, 0, 1, 1));
    for (nt = 0; nt < 2; nt = nt + 1)
    begin
      wr(`OFF_CTRL, nt ? 32'h24 : 32'h0);
      half(0, nt ? 100 : 25);
      half(1, 16);
    end
    wr(`OFF_CONFIG_CLOCK_OUT_DIV, 32'h6);
    half(2, 6);
    ext_pull <= 1'b1;
    repeat (100) @(posedge pclk);
    ext_pull <= 1'b0;
    repeat (4) @(posedge pclk);
    check(system_reset_req, 0);
    ext_pull <= 1'b1;
    repeat (320) @(posedge pclk);
    check(system_reset_req, 1);
    ext_pull <= 1'b0;
    rd(`OFF_IRQ_STATUS, 32'h1e);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check(reset_pin_oe_n, 0);
    rd(`OFF_VOLUME, {24'h0, `VOL_RESET});
    stop_test;
  end
endmodule
